// file: verilog/cis_pkg.sv
/*
 * cis_pkg: constants and carrier types for the cpu interrupt and core
 * state block. Assumes a 10 MHz core clock and an 8-bit data path.
 */
`default_nettype none
package cis_pkg;
   // wishbone register map (word offsets as byte addresses)
   localparam logic [7:0] ADDR_ACC     = 8'h00;
   localparam logic [7:0] ADDR_IDX     = 8'h04;
   localparam logic [7:0] ADDR_PC      = 8'h08;
   localparam logic [7:0] ADDR_SP      = 8'h0c;
   localparam logic [7:0] ADDR_CCR     = 8'h10;
   localparam logic [7:0] ADDR_CMD     = 8'h14;
   localparam logic [7:0] ADDR_ENABLES = 8'h18;
   localparam logic [7:0] ADDR_STATUS  = 8'h1c;
   localparam logic [7:0] ADDR_VECTOR  = 8'h20;
   localparam logic [7:0] ADDR_CAN     = 8'h24;
   localparam logic [7:0] ADDR_SCI     = 8'h28;
   localparam logic [7:0] ADDR_ALU     = 8'h2c;

   // condition flag positions
   localparam int CC_C = 0;
   localparam int CC_Z = 1;
   localparam int CC_N = 2;
   localparam int CC_I = 3;
   localparam int CC_H = 4;

   // reset values
   localparam logic [15:0] SP_RESET  = 16'h00ff;
   localparam logic [9:0]  SP_UPPER  = 10'b0000000011;
   localparam logic [4:0]  CCR_RESET = 5'h08;

   // vector addresses (high byte location; low byte is +1)
   localparam logic [15:0] VEC_RESET    = 16'h3ffe;
   localparam logic [15:0] VEC_SWI      = 16'h3ffc;
   localparam logic [15:0] VEC_EXT      = 16'h3ffa;
   localparam logic [15:0] VEC_CAPTURE  = 16'h3ff8;
   localparam logic [15:0] VEC_COMPARE  = 16'h3ff6;
   localparam logic [15:0] VEC_OVERFLOW = 16'h3ff4;
   localparam logic [15:0] VEC_SCI      = 16'h3ff2;
   localparam logic [15:0] VEC_CAN      = 16'h3ff0;

   localparam logic [7:0] OPC_MUL     = 8'h42;
   localparam int         MUL_CYCLES  = 11;
   localparam int         STACK_IRQ   = 5;
   localparam int         STACK_CALL  = 2;

   // command codes written to the command register
   localparam logic [3:0] CMD_NONE  = 4'h0;
   localparam logic [3:0] CMD_MUL   = 4'h1;
   localparam logic [3:0] CMD_RSP   = 4'h2;
   localparam logic [3:0] CMD_STOP  = 4'h3;
   localparam logic [3:0] CMD_WAIT  = 4'h4;
   localparam logic [3:0] CMD_SWI   = 4'h5;
   localparam logic [3:0] CMD_PUSH  = 4'h6;
   localparam logic [3:0] CMD_PULL  = 4'h7;
   localparam logic [3:0] CMD_CALL  = 4'h8;
   localparam logic [3:0] CMD_RTI   = 4'h9;
   localparam logic [3:0] CMD_ADD   = 4'ha;
   localparam logic [3:0] CMD_ADC   = 4'hb;
   localparam logic [3:0] CMD_SUB   = 4'hc;

   typedef enum logic [2:0] {
      ST_RUN   = 3'b000,
      ST_MUL   = 3'b001,
      ST_STACK = 3'b011,
      ST_WAIT  = 3'b010,
      ST_STOP  = 3'b110
   } cis_state_type;

   typedef struct packed {
      logic capture_one_flag;
      logic capture_two_flag;
      logic compare_one_flag;
      logic compare_two_flag;
      logic timer_overflow_flag;
   } cis_timer_type;

   typedef struct packed {
      logic tx_empty_flag;
      logic tx_complete_flag;
      logic overrun_flag;
      logic rx_full_flag;
      logic idle_flag;
   } cis_sci_type;
endpackage
`default_nettype wire

// file: verilog/cis_core.sv
/*
 * cis_core: interrupt dispatch, stop/wait control and programmer state
 * of the cpu core, reached over a classic wishbone slave.
 * Assumes peripheral flags arrive synchronous to core_clk_i as levels,
 * and that the instruction sequencer drives commands via the bus.
 */
`default_nettype none
module cis_core
   import cis_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // peripheral requests
   input  wire cis_timer_type timer_flags_i,
   input  wire cis_sci_type   sci_flags_i,
   input  wire logic        ext_irq_i,
   input  wire logic        can_rx_done_i,
   input  wire logic        can_tx_done_i,
   input  wire logic [3:0]  can_status_i,
   input  wire logic        can_msg_arrival_i,
   input  wire logic        can_buffers_full_i,
   input  wire logic        can_bus_activity_i,
   input  wire logic        can_sleeping_i,
   // core control outputs
   output logic             cpu_clk_en_o,
   output logic             osc_en_o,
   output logic [15:0]      vector_addr_o,
   output logic             vector_valid_o,
   output logic [4:0]       sci_flag_clear_o
);
   cis_state_type state_reg;
   logic [7:0]  accumulator_reg;
   logic [7:0]  index_reg;
   logic [15:0] program_counter_reg;
   logic [15:0] stack_pointer_reg;
   logic [4:0]  condition_flags_reg;
   logic [4:0]  can_enable_reg;   // rx,tx,err,ovr (wake-up always on)
   logic [2:0]  timer_enable_reg; // capture, compare, overflow
   logic [3:0]  sci_enable_reg;   // txe, txc, rx, idle
   logic [4:0]  can_pending_reg;  // wake,ovr,err,tx,rx
   logic [3:0]  can_status_reg;
   logic        swi_pending_reg;
   logic [3:0]  mul_count_reg;
   logic [2:0]  stack_count_reg;
   logic [4:0]  sci_armed_reg;
   logic [15:0] vector_next;
   logic        irq_any;
   logic        bus_req;
   logic        wr_strobe;
   logic        rd_strobe;
   logic [3:0]  cmd;
   logic [8:0]  alu_sum;
   logic [4:0]  alu_half;
   logic [15:0] product;

   assign bus_req   = cyc_i & stb_i & ~ack_o;
   assign wr_strobe = bus_req & we_i & sel_i[0];
   assign rd_strobe = bus_req & ~we_i;
   assign cmd = (wr_strobe && adr_i == ADDR_CMD && state_reg == ST_RUN)
                ? dat_i[3:0] : CMD_NONE;
   assign product = accumulator_reg * index_reg;
   // maskable sources, each gated by its enable
   logic        cap_req, cmp_req, ovf_req, sci_req, can_req;
   assign cap_req = timer_enable_reg[2] & (timer_flags_i.capture_one_flag
                    | timer_flags_i.capture_two_flag);
   assign cmp_req = timer_enable_reg[1] & (timer_flags_i.compare_one_flag
                    | timer_flags_i.compare_two_flag);
   assign ovf_req = timer_enable_reg[0]
                    & timer_flags_i.timer_overflow_flag;
   assign sci_req = (sci_enable_reg[3] & sci_flags_i.tx_empty_flag)
                  | (sci_enable_reg[2] & sci_flags_i.tx_complete_flag)
                  | (sci_enable_reg[1] & (sci_flags_i.overrun_flag
                     | sci_flags_i.rx_full_flag))
                  | (sci_enable_reg[0] & sci_flags_i.idle_flag);
   assign can_req = |(can_pending_reg & can_enable_reg);
   assign irq_any = ext_irq_i | cap_req | cmp_req | ovf_req
                  | sci_req | can_req;
   // priority encoder; swi ignores the mask bit
   always_comb
   begin
      vector_next = VEC_RESET;
      if (swi_pending_reg)
         vector_next = VEC_SWI;
      else if (ext_irq_i)
         vector_next = VEC_EXT;
      else if (cap_req)
         vector_next = VEC_CAPTURE;
      else if (cmp_req)
         vector_next = VEC_COMPARE;
      else if (ovf_req)
         vector_next = VEC_OVERFLOW;
      else if (sci_req)
         vector_next = VEC_SCI;
      else if (can_req)
         vector_next = VEC_CAN;
   end

   // can source latching: set wins over software clear
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         can_pending_reg <= 5'h00;
         can_status_reg  <= can_status_i; // no false change at release
      end
      else
      begin
         can_status_reg <= can_status_i;
         can_pending_reg <= (can_pending_reg
            & ~((wr_strobe && adr_i == ADDR_CAN) ? dat_i[4:0] : 5'h00))
            | {can_bus_activity_i & can_sleeping_i,
               can_msg_arrival_i & can_buffers_full_i,
               can_status_reg != can_status_i,
               can_tx_done_i,
               can_rx_done_i};
      end
   end

   // serial clear sequence: status read arms, data access clears
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         sci_armed_reg    <= 5'h00;
         sci_flag_clear_o <= 5'h00;
      end
      else
      begin
         sci_flag_clear_o <= 5'h00;
         if (rd_strobe && adr_i == ADDR_STATUS)
            sci_armed_reg <= sci_flags_i;
         else if (bus_req && adr_i == ADDR_SCI)
         begin
            sci_flag_clear_o <= sci_armed_reg;
            sci_armed_reg    <= 5'h00;
         end
      end
   end

   // control state machine
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         state_reg       <= ST_RUN;
         mul_count_reg   <= 4'h0;
         stack_count_reg <= 3'h0;
         swi_pending_reg <= 1'b0;
         cpu_clk_en_o    <= 1'b1;
         osc_en_o        <= 1'b1;
         vector_addr_o   <= VEC_RESET;
         vector_valid_o  <= 1'b1;
      end
      else
      begin
         vector_valid_o <= 1'b0;
         case (state_reg)
            ST_RUN:
            begin
               if (cmd == CMD_SWI)
                  swi_pending_reg <= 1'b1;
               if (cmd == CMD_MUL)
               begin
                  state_reg     <= ST_MUL;
                  mul_count_reg <= 4'(MUL_CYCLES - 1);
               end
               else if (cmd == CMD_WAIT)
               begin
                  state_reg    <= ST_WAIT;
                  cpu_clk_en_o <= 1'b0;
               end
               else if (cmd == CMD_STOP)
               begin
                  state_reg    <= ST_STOP;
                  cpu_clk_en_o <= 1'b0;
                  osc_en_o     <= ~can_sleeping_i;
               end
               else if (swi_pending_reg
                        || (irq_any && !condition_flags_reg[CC_I]))
               begin
                  state_reg       <= ST_STACK;
                  stack_count_reg <= 3'(STACK_IRQ - 1);
                  swi_pending_reg <= 1'b0;
                  vector_addr_o   <= vector_next;
               end
            end
            ST_MUL:
            begin
               mul_count_reg <= mul_count_reg - 4'h1;
               if (mul_count_reg == 4'h1)
                  state_reg <= ST_RUN;
            end
            ST_STACK:
            begin
               stack_count_reg <= stack_count_reg - 3'h1;
               if (stack_count_reg == 3'h0)
               begin
                  state_reg      <= ST_RUN;
                  vector_valid_o <= 1'b1;
               end
            end
            ST_WAIT:
               if (ext_irq_i || cap_req || cmp_req || ovf_req || sci_req)
               begin
                  state_reg    <= ST_RUN;
                  cpu_clk_en_o <= 1'b1;
               end
            ST_STOP:
               if (ext_irq_i || can_req)
               begin
                  state_reg    <= ST_RUN;
                  cpu_clk_en_o <= 1'b1;
                  osc_en_o     <= 1'b1;
               end
            default:
               state_reg <= ST_RUN;
         endcase
      end
   end

   // alu for add/adc/sub feeding the flags
   always_comb
   begin
      alu_sum  = {1'b0, accumulator_reg} + {1'b0, dat_i[15:8]}
               + {8'h00, cmd == CMD_ADC && condition_flags_reg[CC_C]};
      alu_half = {1'b0, accumulator_reg[3:0]} + {1'b0, dat_i[11:8]}
               + {4'h0, cmd == CMD_ADC && condition_flags_reg[CC_C]};
      if (cmd == CMD_SUB)
      begin
         alu_sum  = {1'b0, accumulator_reg} - {1'b0, dat_i[15:8]};
         alu_half = 5'h00;
      end
   end

   // programmer registers
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         accumulator_reg     <= 8'h00;
         index_reg           <= 8'h00;
         program_counter_reg <= VEC_RESET;
         stack_pointer_reg   <= SP_RESET;
         condition_flags_reg <= CCR_RESET;
      end
      else
      begin
         if (state_reg == ST_MUL && mul_count_reg == 4'h1)
         begin
            index_reg           <= product[15:8];
            accumulator_reg     <= product[7:0];
            condition_flags_reg[CC_H] <= 1'b0;
            condition_flags_reg[CC_C] <= 1'b0;
         end
         else if (state_reg == ST_STACK)
         begin
            stack_pointer_reg <= {SP_UPPER,
                                  6'(stack_pointer_reg[5:0] - 6'h01)};
            if (stack_count_reg == 3'h0)
            begin
               condition_flags_reg[CC_I] <= 1'b1;
               program_counter_reg <= {2'b00, vector_addr_o[13:0]};
            end
         end
         else if (cmd == CMD_ADD || cmd == CMD_ADC || cmd == CMD_SUB)
         begin
            accumulator_reg           <= alu_sum[7:0];
            condition_flags_reg[CC_H] <= alu_half[4];
            condition_flags_reg[CC_C] <= alu_sum[8];
            condition_flags_reg[CC_N] <= alu_sum[7];
            condition_flags_reg[CC_Z] <= alu_sum[7:0] == 8'h00;
         end
         else if (cmd == CMD_RSP)
            stack_pointer_reg <= SP_RESET;
         else if (cmd == CMD_PUSH || cmd == CMD_CALL)
            stack_pointer_reg <= {SP_UPPER, 6'(stack_pointer_reg[5:0]
               - (cmd == CMD_CALL ? 6'(STACK_CALL) : 6'h01))};
         else if (cmd == CMD_PULL || cmd == CMD_RTI)
            stack_pointer_reg <= {SP_UPPER, 6'(stack_pointer_reg[5:0]
               + (cmd == CMD_RTI ? 6'(STACK_IRQ) : 6'h01))};
         else if (wr_strobe && state_reg == ST_RUN)
            case (adr_i)
               ADDR_ACC: accumulator_reg <= dat_i[7:0];
               ADDR_IDX: index_reg       <= dat_i[7:0];
               ADDR_PC:  program_counter_reg <= {2'b00, dat_i[13:0]};
               ADDR_CCR: condition_flags_reg <= dat_i[4:0];
               default:  ;
            endcase
      end
   end

   // enables and bus answer
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         can_enable_reg   <= 5'h10; // wake-up source never masked
         timer_enable_reg <= 3'h0;
         sci_enable_reg   <= 4'h0;
         ack_o            <= 1'b0;
         dat_o            <= 32'h0;
      end
      else
      begin
         ack_o <= bus_req;
         dat_o <= 32'h0;
         if (wr_strobe && adr_i == ADDR_ENABLES)
         begin
            can_enable_reg   <= {1'b1, dat_i[3:0]};
            timer_enable_reg <= dat_i[6:4];
            sci_enable_reg   <= dat_i[10:7];
         end
         if (rd_strobe)
            case (adr_i)
               ADDR_ACC:     dat_o <= {24'h0, accumulator_reg};
               ADDR_IDX:     dat_o <= {24'h0, index_reg};
               ADDR_PC:      dat_o <= {16'h0, 2'b00,
                                       program_counter_reg[13:0]};
               ADDR_SP:      dat_o <= {16'h0, stack_pointer_reg};
               ADDR_CCR:     dat_o <= {27'h0, condition_flags_reg};
               ADDR_ENABLES: dat_o <= {21'h0, sci_enable_reg,
                                       timer_enable_reg, can_enable_reg[3:0]};
               ADDR_STATUS:  dat_o <= {19'h0, state_reg, 5'(sci_flags_i),
                                       5'(timer_flags_i)};
               ADDR_VECTOR:  dat_o <= {16'h0, vector_addr_o};
               ADDR_CAN:     dat_o <= {27'h0, can_pending_reg};
               default:      dat_o <= 32'h0;
            endcase
      end
   end
endmodule
`default_nettype wire

// file: sim/cis_core_properties.sv
/*
 * cis_core_properties: port-level checks of cis_core.
 * Assumes it is bound into cis_core and that flags are held levels.
 */
`default_nettype none
module cis_core_properties
   import cis_pkg::*;
(
   // clock and reset
   input wire logic          core_clk_i,
   input wire logic          nrst_i,
   // bus
   input wire logic          cyc_i,
   input wire logic          stb_i,
   input wire logic          we_i,
   input wire logic [7:0]    adr_i,
   input wire logic [31:0]   dat_o,
   input wire logic          ack_o,
   // requests
   input wire cis_timer_type timer_flags_i,
   input wire cis_sci_type   sci_flags_i,
   input wire logic          can_sleeping_i,
   // core control
   input wire logic          cpu_clk_en_o,
   input wire logic          osc_en_o,
   input wire logic [15:0]   vector_addr_o,
   input wire logic          vector_valid_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   chk_ack_one_cycle: assert property
      (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked after one cycle");
   chk_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_reset_vector: assert property
      ($rose(nrst_i) |-> ##[0:1]
       (vector_valid_o && vector_addr_o == VEC_RESET))
      else $error("reset vector missing");
   chk_vector_pulse: assert property
      (nrst_i && vector_valid_o |=> !vector_valid_o)
      else $error("vector valid longer than one cycle");
   chk_capture_cause: assert property
      (vector_valid_o && vector_addr_o == VEC_CAPTURE
       |-> timer_flags_i.capture_one_flag || timer_flags_i.capture_two_flag)
      else $error("capture vector without capture flag");
   chk_compare_cause: assert property
      (vector_valid_o && vector_addr_o == VEC_COMPARE
       |-> timer_flags_i.compare_one_flag || timer_flags_i.compare_two_flag)
      else $error("compare vector without compare flag");
   chk_serial_cause: assert property
      (vector_valid_o && vector_addr_o == VEC_SCI |-> sci_flags_i != 5'h00)
      else $error("serial vector without serial flag");
   chk_stop_halts: assert property (!osc_en_o |-> !cpu_clk_en_o)
      else $error("processor clocks run with oscillator off");
   chk_osc_sleep_only: assert property
      ($fell(osc_en_o) |-> $past(can_sleeping_i))
      else $error("oscillator stopped while controller awake");
   chk_pc_top_zero: assert property
      (ack_o && !we_i && adr_i == ADDR_PC |-> dat_o[15:14] == 2'b00)
      else $error("program counter top bits not zero");
   chk_sp_page: assert property
      (ack_o && !we_i && adr_i == ADDR_SP |-> dat_o[15:6] == SP_UPPER)
      else $error("stack pointer outside stack page");
endmodule
`default_nettype wire

// file: sim/cis_periph_model.sv
/*
 * cis_periph_model: timer and serial flag sources facing cis_core.
 * Assumes the bench pulses set/clear inputs one cycle at a time.
 */
`default_nettype none
module cis_periph_model
   import cis_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   // bench stimulus
   input  wire logic [4:0] timer_set_i,
   input  wire logic [4:0] sci_set_i,
   input  wire logic       clr_i,
   // clear pulses from the core
   input  wire logic [4:0] sci_flag_clear_i,
   // flag levels
   output cis_timer_type   timer_flags_o,
   output cis_sci_type     sci_flags_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // flags stay up until cleared, as the real peripherals do
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i || clr_i)
         timer_flags_o <= '0;
      else
         timer_flags_o <= cis_timer_type'(timer_flags_o | timer_set_i);
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i || clr_i)
         sci_flags_o <= '0;
      else
         sci_flags_o <= cis_sci_type'((sci_flags_o & ~sci_flag_clear_i)
                                      | sci_set_i);
   end
endmodule
`default_nettype wire

// file: sim/tb.sv
/*
 * tb: self-checking bench for cis_core, wishbone master and row table.
 * Assumes cis_periph_model for flags and the bound property checker.
 */
`default_nettype none
module tb
   import cis_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      logic [4:0]  tset;
      logic [4:0]  sset;
      logic        ext;
      logic [2:0]  can;
      logic [15:0] en;
      logic [15:0] vec;
   } cis_row_type;

   logic          core_clk_i = 1'b0, nrst_i = 1'b0, cyc_i = 1'b0;
   logic          stb_i = 1'b0, we_i = 1'b0, ack_o, clr = 1'b0;
   logic [7:0]    adr_i = 8'h00;
   logic [3:0]    sel_i = 4'hf, can_status_i = 4'h0;
   logic [31:0]   dat_i = 32'h0, dat_o, q;
   logic          ext_irq_i = 1'b0, can_rx_done_i = 1'b0;
   logic          can_tx_done_i = 1'b0, can_msg_arrival_i = 1'b0;
   logic          can_buffers_full_i = 1'b0, can_bus_activity_i = 1'b0;
   logic          can_sleeping_i = 1'b0, cpu_clk_en_o, osc_en_o;
   logic          vector_valid_o;
   logic [15:0]   vector_addr_o, v;
   logic [4:0]    sci_flag_clear_o, tset = 5'h00, sset = 5'h00;
   cis_timer_type timer_flags_i;
   cis_sci_type   sci_flags_i;
   int            error_cnt = 0, samples_checked = 0, cycle_cnt = 0;
   cis_row_type   rows [15] = '{
      '{5'h10, 5'h00, 1'b0, 3'h0, 16'h040, VEC_CAPTURE},
      '{5'h08, 5'h00, 1'b0, 3'h0, 16'h020, 16'h0000},
      '{5'h02, 5'h00, 1'b0, 3'h0, 16'h020, VEC_COMPARE},
      '{5'h01, 5'h00, 1'b0, 3'h0, 16'h010, VEC_OVERFLOW},
      '{5'h00, 5'h04, 1'b0, 3'h0, 16'h100, VEC_SCI},
      '{5'h00, 5'h02, 1'b0, 3'h0, 16'h400, 16'h0000},
      '{5'h00, 5'h10, 1'b0, 3'h0, 16'h400, VEC_SCI},
      '{5'h00, 5'h08, 1'b0, 3'h0, 16'h200, VEC_SCI},
      '{5'h00, 5'h01, 1'b0, 3'h0, 16'h080, VEC_SCI},
      '{5'h04, 5'h00, 1'b1, 3'h0, 16'h7ff, VEC_EXT},
      '{5'h00, 5'h10, 1'b0, 3'h1, 16'h7ff, VEC_SCI},
      '{5'h00, 5'h00, 1'b0, 3'h1, 16'h00f, VEC_CAN},
      '{5'h00, 5'h00, 1'b0, 3'h2, 16'h00f, VEC_CAN},
      '{5'h00, 5'h00, 1'b0, 3'h4, 16'h00f, VEC_CAN},
      '{5'h00, 5'h00, 1'b0, 3'h1, 16'h000, 16'h0000}};

   always #50 core_clk_i = ~core_clk_i;

   cis_periph_model i_model (.core_clk_i, .nrst_i, .timer_set_i(tset),
      .sci_set_i(sset), .clr_i(clr), .sci_flag_clear_i(sci_flag_clear_o),
      .timer_flags_o(timer_flags_i), .sci_flags_o(sci_flags_i));

   cis_core i_dut (.core_clk_i, .nrst_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .timer_flags_i, .sci_flags_i,
      .ext_irq_i, .can_rx_done_i, .can_tx_done_i, .can_status_i,
      .can_msg_arrival_i, .can_buffers_full_i, .can_bus_activity_i,
      .can_sleeping_i, .cpu_clk_en_o, .osc_en_o, .vector_addr_o,
      .vector_valid_o, .sci_flag_clear_o);

   task automatic results();
      if (error_cnt == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   // one classic cycle; ack is sampled at the edge, request held till then
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge core_clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      r = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
      if (n == 20)
         chk("bus ack", 32'h0, 32'h1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input string n, input logic [7:0] a,
                         input logic [31:0] e);
      wb(1'b0, a, 32'h0, q);
      chk(n, q, e);
   endtask

   task automatic wait_vec(input int lim);
      v = 16'h0;
      repeat (lim)
      begin
         @(posedge core_clk_i);
         if (vector_valid_o === 1'b1)
         begin
            v = vector_addr_o;
            break;
         end
      end
   endtask

   // poll the state field rather than assume a command latency
   task automatic wait_run();
      int n;
      n = 0;
      do
      begin
         wb(1'b0, ADDR_STATUS, 32'h0, q);
         n++;
      end
      while (q[12:10] !== 3'b000 && n < 20);
   endtask

   task automatic cmd_sp(input logic [3:0] c, input logic [31:0] e);
      wr(ADDR_CMD, {28'h0, c});
      wait_run();
      rd_chk("sp", ADDR_SP, e);
   endtask

   task automatic alu(input logic [3:0] c, input logic [7:0] a, b, ea,
                      input logic [4:0] ec);
      wr(ADDR_ACC, {24'h0, a});
      wr(ADDR_CMD, {16'h0, b, 4'h0, c});
      wait_run();
      rd_chk("acc", ADDR_ACC, {24'h0, ea});
      rd_chk("ccr", ADDR_CCR, {27'h0, ec});
   endtask

   task automatic clean();
      {clr, ext_irq_i} <= 2'b10;
      @(posedge core_clk_i);
      clr <= 1'b0;
      wr(ADDR_CAN, 32'h1f);
      cmd_sp(CMD_RSP, 32'h00ff);
   endtask

   always @(posedge core_clk_i)
   begin
      cycle_cnt++;
      if (cycle_cnt == 20000)
      begin
         error_cnt++;
         results();
      end
   end

   initial
   begin
      repeat (8) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      foreach (rows[i])
      begin
         wr(ADDR_ENABLES, {16'h0, rows[i].en});
         wr(ADDR_CCR, 32'h08);
         {tset, sset, ext_irq_i} <= {rows[i].tset, rows[i].sset, rows[i].ext};
         {can_rx_done_i, can_msg_arrival_i, can_buffers_full_i} <=
            {rows[i].can[0], rows[i].can[2], rows[i].can[2]};
         can_status_i <= can_status_i ^ {3'h0, rows[i].can[1]};
         @(posedge core_clk_i);
         {tset, sset, can_rx_done_i, can_msg_arrival_i} <= 12'h000;
         wait_vec(6);
         chk("masked", {16'h0, v}, 32'h0);
         wr(ADDR_CCR, 32'h00);
         wait_vec(30);
         chk("vector", {16'h0, v}, {16'h0, rows[i].vec});
         if (rows[i].vec != 16'h0)
         begin
            rd_chk("ccr mask", ADDR_CCR, 32'h08);
            rd_chk("sp stacked", ADDR_SP, 32'h00fa);
         end
         clean();
      end
      wr(ADDR_CCR, 32'h08);
      alu(CMD_ADD, 8'h0f, 8'h01, 8'h10, 5'h18);
      alu(CMD_ADD, 8'h80, 8'h80, 8'h00, 5'h0b);
      alu(CMD_ADC, 8'h01, 8'h01, 8'h03, 5'h08);
      alu(CMD_ADD, 8'h7f, 8'h01, 8'h80, 5'h1c);
      wr(ADDR_IDX, 32'h13);
      wr(ADDR_CCR, 32'h13);
      alu(CMD_MUL, 8'hfe, 8'h00, 8'hda, 5'h02);
      rd_chk("idx", ADDR_IDX, 32'h12);
      wr(ADDR_PC, 32'hffff);
      rd_chk("pc", ADDR_PC, 32'h3fff);
      cmd_sp(CMD_PUSH, 32'h00fe);
      cmd_sp(CMD_CALL, 32'h00fc);
      cmd_sp(CMD_PULL, 32'h00fd);
      cmd_sp(CMD_RTI, 32'h00c2);
      cmd_sp(CMD_RSP, 32'h00ff);
      wr(8'h30, 32'hff);
      rd_chk("unmapped", 8'h30, 32'h0);
      wr(ADDR_ENABLES, 32'h0);
      sset <= 5'h02;
      @(posedge core_clk_i);
      sset <= 5'h00;
      wb(1'b0, ADDR_SCI, 32'h0, q);
      chk("rx kept", {31'h0, sci_flags_i.rx_full_flag}, 32'h1);
      wb(1'b0, ADDR_STATUS, 32'h0, q);
      chk("status", {27'h0, q[9:5]}, 32'h02);
      wb(1'b0, ADDR_SCI, 32'h0, q);
      repeat (2) @(posedge core_clk_i);
      chk("rx cleared", {31'h0, sci_flags_i.rx_full_flag}, 32'h0);
      wr(ADDR_ENABLES, 32'h010);
      wr(ADDR_CCR, 32'h00);
      wr(ADDR_CMD, {28'h0, CMD_WAIT});
      repeat (2) @(posedge core_clk_i);
      chk("wait", {30'h0, cpu_clk_en_o, osc_en_o}, 32'h1);
      tset <= 5'h01;
      @(posedge core_clk_i);
      tset <= 5'h00;
      wait_vec(30);
      chk("wait exit", {16'h0, v}, {16'h0, VEC_OVERFLOW});
      clean();
      can_sleeping_i <= 1'b1;
      wr(ADDR_ENABLES, 32'h0);
      wr(ADDR_CCR, 32'h00);
      wr(ADDR_CMD, {28'h0, CMD_STOP});
      repeat (2) @(posedge core_clk_i);
      chk("stop", {30'h0, cpu_clk_en_o, osc_en_o}, 32'h0);
      can_bus_activity_i <= 1'b1;
      @(posedge core_clk_i);
      can_bus_activity_i <= 1'b0;
      wait_vec(30);
      chk("wake", {16'h0, v}, {16'h0, VEC_CAN});
      can_sleeping_i <= 1'b0;
      clean();
      chk("clk back", {30'h0, cpu_clk_en_o, osc_en_o}, 32'h3);
      wr(ADDR_CMD, {28'h0, CMD_SWI});
      wait_vec(30);
      chk("swi", {16'h0, v}, {16'h0, VEC_SWI});
      rd_chk("sp swi", ADDR_SP, 32'h00fa);
      nrst_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      rd_chk("ccr rst", ADDR_CCR, 32'h08);
      rd_chk("sp rst", ADDR_SP, 32'h00ff);
      rd_chk("pc rst", ADDR_PC, {16'h0, VEC_RESET});
      rd_chk("can rst", ADDR_CAN, 32'h0);
      results();
   end
endmodule

bind cis_core cis_core_properties i_chk (.core_clk_i, .nrst_i, .cyc_i,
   .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .timer_flags_i, .sci_flags_i,
   .can_sleeping_i, .cpu_clk_en_o, .osc_en_o, .vector_addr_o,
   .vector_valid_o);
`default_nettype wire
